// ===== ssp_pkg.sv
// shared constants and types of the serial eeprom select and protect block
//
// Notes on behaviour
// [RULE_01] select low selects; high deselects into standby
// [RULE_02] started program cycle finishes; standby only afterwards
// [RULE_03] serial output floats whenever device is deselected
// [RULE_04] select rising after valid write starts cycle
// [RULE_05] internal write cycle lasts at most 6 ms
// [RULE_06] select must go low once after power-up
// [RULE_07] output bits change after falling serial clock
// [RULE_08] protect pin low plus enable blocks status writes
// [RULE_09] protect pin high lets everything work normally
// [RULE_10] protect pin change ignored once write started
// [RULE_11] enable bit clear makes protect pin ignored
// [RULE_12] serial input sampled on rising serial clock
// [RULE_13] all bytes travel most significant bit first
// [RULE_14] deselect ignores clock and resets bit counter
// [RULE_15] protection sampled at status write sequence end
package ssp_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 100; // system clock rate
	localparam int unsigned TWC_MS = 6; // longest internal write time
	// longest time, so rounded down to whole cycles
	localparam int unsigned TWC_CYCLES = TWC_MS * CLK_MHZ * 1000;
	localparam int WCNT_W = 20; // wide enough for the write count

	// ------------------------------------------------------------
	// widths and depths
	// ------------------------------------------------------------
	localparam int BYTE_W = 8; // serial byte
	localparam int FIFO_DEPTH = 4; // received byte buffer
	localparam int CNT_W = 3; // bit and byte counters

	// ------------------------------------------------------------
	// instruction codes and sequence lengths
	// ------------------------------------------------------------
	localparam logic [7:0] OP_WRSR = 8'h01; // status write
	localparam logic [7:0] OP_WRITE = 8'h02; // array write
	localparam logic [7:0] OP_WRDI = 8'h04; // clear write enable
	localparam logic [7:0] OP_RDSR = 8'h05; // status read
	localparam logic [7:0] OP_WREN = 8'h06; // set write enable
	localparam logic [2:0] LEN_CTRL = 3'h1; // one byte commands
	localparam logic [2:0] LEN_WRSR_MIN = 3'h2; // opcode plus value
	localparam logic [2:0] LEN_WRITE_MIN = 3'h4; // opcode, address, data
	localparam logic [2:0] CNT_LAST = 3'h7; // last bit / saturation

	// ------------------------------------------------------------
	// status word layout and reset values
	// ------------------------------------------------------------
	localparam int ST_PEN = 7; // protect pin enable
	localparam int ST_BP1 = 3; // block protect high
	localparam int ST_BP0 = 2; // block protect low
	localparam int ST_WEL = 1; // write enable latch
	localparam int ST_WIP = 0; // write in progress
	localparam logic PEN_RST = 1'b0;
	localparam logic [1:0] BP_RST = 2'h0;
	localparam logic WEL_RST = 1'b0;
	localparam logic [3:0] PIN_SYNC_RST = 4'hc; // select, wp high

	// frame tracking states
	typedef enum logic [1:0] {FR_UNARMED, FR_IDLE, FR_ACTIVE, FR_DRAIN}
		ssp_frame_e;

endpackage : ssp_pkg

// ===== ssp_stream_if.sv
// valid/ready byte stream between the block's own modules
`timescale 1ns/10ps
interface ssp_stream_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] data; // payload
	logic valid; // payload offered
	logic ready; // payload accepted
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : ssp_stream_if

// ===== ssp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module ssp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta; // read only by q

	// first stage feeds the second and nothing else
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta <= RST;
			q <= RST;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : ssp_sync

// ===== ssp_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module ssp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// fill and drain sides
	ssp_stream_if.snk wr,
	ssp_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [AW-1:0] wr_ptr; // next slot to fill
	logic [AW-1:0] rd_ptr; // oldest slot
	logic [CW-1:0] count; // words held
	logic push;
	logic pop;

	// wrap a pointer at the depth, which need not be a power of two
	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : ptr_inc

	assign wr.ready = (count != CW'(DEPTH));
	assign rd.valid = (count != '0);
	assign rd.data = mem[rd_ptr];
	assign push = wr.valid && wr.ready;
	assign pop = rd.valid && rd.ready;

	// storage write
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= wr.data;
	end

	// pointers and fill level
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= ptr_inc(wr_ptr);
			if (pop)
				rd_ptr <= ptr_inc(rd_ptr);
			if (push && !pop)
				count <= CW'(count + 1'b1);
			else if (pop && !push)
				count <= CW'(count - 1'b1);
		end
	end
endmodule : ssp_fifo

// ===== serial_eeprom_select_protect.sv
// serial eeprom select, output drive and write protect control
`timescale 1ns/10ps
module serial_eeprom_select_protect #(
	parameter int unsigned WRITE_CYCLES = ssp_pkg::TWC_CYCLES
) (
	// system clock and reset
	input wire logic clk,
	input wire logic rstn,
	// serial link pins
	input wire logic sck,
	input wire logic sel_n,
	input wire logic si,
	output logic so,
	output logic so_oe_n,
	// write protect pin
	input wire logic wp_n,
	// device state
	output logic selected,
	output logic standby,
	output logic write_busy,
	output logic write_enable_latch,
	output logic protect_pin_enable,
	output logic [1:0] block_protect,
	// received byte stream
	output logic [ssp_pkg::BYTE_W-1:0] rx_byte,
	output logic rx_first,
	output logic rx_valid,
	input wire logic rx_ready,
	// array write finished
	output logic array_commit
);
	import ssp_pkg::*;

	// ------------------------------------------------------------
	// link clock domain
	// ------------------------------------------------------------
	logic link_clr; // frame end or system reset
	logic [CNT_W-1:0] bit_cnt; // bit within current byte
	logic [6:0] rx_shift; // bits gathered so far
	logic [BYTE_W-1:0] link_byte; // last whole byte
	logic start_tgl; // flips at first bit of each byte
	logic done_tgl; // flips at last bit of each byte
	logic first_done; // opcode byte already taken
	logic rd_status; // status read under way
	logic [6:0] tx_shift; // bits still to send
	logic [BYTE_W-1:0] status_word; // system side status
	logic [BYTE_W-1:0] status_link; // status seen by link side

	// the frame's own signal ends the frame state, since the clock
	// from the master may stop right after the last bit
	assign link_clr = sel_n | ~rstn;

	// per-frame counters, cleared while deselected
	always_ff @(posedge sck or posedge link_clr)
	begin
		if (link_clr)
		begin
			bit_cnt <= '0; // [RULE_14]
			first_done <= 1'b0;
			rd_status <= 1'b0;
		end
		else
		begin
			bit_cnt <= CNT_W'(bit_cnt + 1'b1);
			if (bit_cnt == CNT_LAST)
			begin
				first_done <= 1'b1;
				// opcode decode only for the status read path
				if (!first_done && {rx_shift, si} == OP_RDSR)
					rd_status <= 1'b1;
			end
		end
	end

	// input shifter and byte events; deselected edges do nothing
	always_ff @(posedge sck or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_shift <= '0;
			link_byte <= '0;
			start_tgl <= 1'b0;
			done_tgl <= 1'b0;
		end
		else if (!sel_n) // [RULE_14]
		begin
			rx_shift <= {rx_shift[5:0], si}; // [RULE_12] [RULE_13]
			if (bit_cnt == '0)
				start_tgl <= ~start_tgl;
			if (bit_cnt == CNT_LAST)
			begin
				link_byte <= {rx_shift, si}; // [RULE_13]
				done_tgl <= ~done_tgl;
			end
		end
	end

	// output driver, updated on the falling edge only
	always_ff @(negedge sck or posedge link_clr)
	begin
		if (link_clr)
		begin
			so_oe_n <= 1'b1; // [RULE_03]
			so <= 1'b0;
			tx_shift <= '0;
		end
		else if (rd_status)
		begin
			so_oe_n <= 1'b0;
			// reload at each byte boundary so polling sees fresh state
			if (bit_cnt == '0)
			begin
				so <= status_link[BYTE_W-1]; // [RULE_07] [RULE_13]
				tx_shift <= status_link[6:0];
			end
			else
			begin
				so <= tx_shift[6]; // [RULE_07]
				tx_shift <= {tx_shift[5:0], 1'b0};
			end
		end
	end

	// status bits are slow levels, so a per-bit sync is enough;
	// the link clock gives eight edges before the first read bit
	ssp_sync #(.WIDTH(BYTE_W), .RST('0)) u_status_sync (
		.clk(sck),
		.rstn(rstn),
		.d(status_word),
		.q(status_link)
	);

	// ------------------------------------------------------------
	// crossing into the system clock domain
	// ------------------------------------------------------------
	logic sel_s; // synced select, high means deselected
	logic wp_s; // synced protect pin
	logic start_s; // synced start toggle
	logic done_s; // synced done toggle
	logic sel_q; // previous synced select
	logic start_q; // previous start toggle
	logic done_q; // previous done toggle
	logic sel_fall;
	logic sel_rise;
	logic start_pulse;
	logic done_pulse;

	ssp_sync #(.WIDTH(4), .RST(PIN_SYNC_RST)) u_pin_sync (
		.clk(clk),
		.rstn(rstn),
		.d({sel_n, wp_n, start_tgl, done_tgl}),
		.q({sel_s, wp_s, start_s, done_s})
	);

	// edge detection on synced copies only
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sel_q <= 1'b1;
			start_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			sel_q <= sel_s;
			start_q <= start_s;
			done_q <= done_s;
		end
	end

	assign sel_fall = sel_q & ~sel_s;
	assign sel_rise = ~sel_q & sel_s;
	assign start_pulse = start_s ^ start_q;
	assign done_pulse = done_s ^ done_q;

	// ------------------------------------------------------------
	// received byte buffer
	// ------------------------------------------------------------
	ssp_stream_if #(.WIDTH(BYTE_W)) fill_if ();
	ssp_stream_if #(.WIDTH(BYTE_W)) drain_if ();

	ssp_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk(clk),
		.rstn(rstn),
		.wr(fill_if.snk),
		.rd(drain_if.src)
	);

	// drain stalls when the consumer holds off; that fills the fifo
	assign drain_if.ready = !rx_valid || rx_ready;

	// ------------------------------------------------------------
	// frame tracking
	// ------------------------------------------------------------
	ssp_frame_e frame; // frame state
	logic [CNT_W-1:0] byte_cnt; // whole bytes, saturating
	logic [BYTE_W-1:0] opcode; // first byte of the frame
	logic [BYTE_W-1:0] wsr_value; // second byte of the frame
	logic frame_ok; // no byte lost in this frame
	logic partial; // a byte was begun and not finished
	logic drained; // nothing of the frame still in flight
	logic eval; // one-cycle end of frame decision
	logic seq_valid; // byte aligned, nothing lost
	logic pop;

	assign pop = drain_if.valid && drain_if.ready;
	assign drained = !fill_if.valid && !drain_if.valid && !done_pulse;
	assign eval = (frame == FR_DRAIN) && drained;
	assign seq_valid = frame_ok && !partial && (byte_cnt != '0);

	// frame state; nothing counts before select has been low once
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			frame <= FR_UNARMED;
		else
		begin
			case (frame)
				FR_UNARMED:
					if (!sel_s) // [RULE_06]
						frame <= FR_IDLE;
				FR_IDLE:
					if (sel_fall)
						frame <= FR_ACTIVE;
				FR_ACTIVE:
					if (sel_rise)
						frame <= FR_DRAIN;
				FR_DRAIN:
					// a frame that began while draining is spoiled below
					if (drained)
						frame <= sel_s ? FR_IDLE : FR_ACTIVE;
				default:
					frame <= FR_UNARMED;
			endcase
		end
	end

	// push finished bytes; the link byte holds for a whole byte time
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			fill_if.valid <= 1'b0;
			fill_if.data <= '0;
		end
		else
		begin
			fill_if.valid <= done_pulse && (frame == FR_ACTIVE);
			if (done_pulse)
				fill_if.data <= link_byte;
		end
	end

	// per-frame bookkeeping: length, opcode, alignment, losses
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			byte_cnt <= '0;
			opcode <= '0;
			wsr_value <= '0;
			frame_ok <= 1'b0;
			partial <= 1'b0;
		end
		else if (frame == FR_IDLE && sel_fall)
		begin
			byte_cnt <= '0;
			frame_ok <= 1'b1;
			partial <= 1'b0;
		end
		else if (eval)
		begin
			byte_cnt <= '0;
			frame_ok <= 1'b0; // re-entered frame lost its start
			partial <= 1'b0;
		end
		else
		begin
			if (start_pulse)
				partial <= 1'b1;
			else if (done_pulse)
				partial <= 1'b0;
			// a full buffer drops the byte and voids the frame
			if (fill_if.valid && !fill_if.ready)
				frame_ok <= 1'b0;
			if (pop)
			begin
				if (byte_cnt == '0)
					opcode <= drain_if.data;
				if (byte_cnt == 3'h1)
					wsr_value <= drain_if.data;
				if (byte_cnt != CNT_LAST)
					byte_cnt <= CNT_W'(byte_cnt + 1'b1);
			end
		end
	end

	// received byte output register
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_byte <= '0;
			rx_first <= 1'b0;
			rx_valid <= 1'b0;
		end
		else if (pop)
		begin
			rx_byte <= drain_if.data;
			rx_first <= (byte_cnt == '0);
			rx_valid <= 1'b1;
		end
		else if (rx_ready)
			rx_valid <= 1'b0;
	end

	// ------------------------------------------------------------
	// write protect and write cycle
	// ------------------------------------------------------------
	logic [WCNT_W-1:0] wcnt; // cycles left in the write
	logic cyc_status; // running write targets the status bits
	logic pend_pen; // status value waiting for the write
	logic [1:0] pend_bp;
	logic cyc_end; // last cycle of the internal write
	logic start_array;
	logic start_status;

	// protection only counts while the enable bit is set
	function automatic logic status_locked(input logic wp_level,
		input logic pen);
		status_locked = !wp_level && pen; // [RULE_08] [RULE_09] [RULE_11]
	endfunction : status_locked

	assign cyc_end = write_busy && (wcnt == '0);
	// only the select rise that closes a whole sequence starts a write
	assign start_array = eval && !write_busy && seq_valid
		&& write_enable_latch && (opcode == OP_WRITE)
		&& (byte_cnt >= LEN_WRITE_MIN); // [RULE_04]
	// protection is sampled once, at the end of the status sequence
	assign start_status = eval && !write_busy && seq_valid
		&& write_enable_latch && (opcode == OP_WRSR)
		&& (byte_cnt >= LEN_WRSR_MIN)
		&& !status_locked(wp_s, protect_pin_enable); // [RULE_15] [RULE_04]

	// internal write timer; select and the pin cannot stop it
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			write_busy <= 1'b0;
			wcnt <= '0;
			cyc_status <= 1'b0;
			pend_pen <= PEN_RST;
			pend_bp <= BP_RST;
		end
		else if (write_busy)
		begin
			if (cyc_end)
				write_busy <= 1'b0; // [RULE_02] [RULE_10]
			else
				wcnt <= WCNT_W'(wcnt - 1'b1); // [RULE_05]
		end
		else if (start_array || start_status)
		begin
			write_busy <= 1'b1;
			wcnt <= WCNT_W'(WRITE_CYCLES - 1); // [RULE_05]
			cyc_status <= start_status;
			pend_pen <= wsr_value[ST_PEN];
			pend_bp <= {wsr_value[ST_BP1], wsr_value[ST_BP0]};
		end
	end

	// write enable latch: commands only act outside a write
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			write_enable_latch <= WEL_RST;
		else if (cyc_end)
			write_enable_latch <= 1'b0;
		else if (eval && !write_busy && seq_valid && byte_cnt == LEN_CTRL)
		begin
			if (opcode == OP_WREN)
				write_enable_latch <= 1'b1;
			else if (opcode == OP_WRDI)
				write_enable_latch <= 1'b0;
		end
	end

	// nonvolatile status bits change only when their write completes
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			protect_pin_enable <= PEN_RST;
			block_protect <= BP_RST;
		end
		else if (cyc_end && cyc_status)
		begin
			protect_pin_enable <= pend_pen;
			block_protect <= pend_bp;
		end
	end

	// array commit strobe for the storage behind this block
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			array_commit <= 1'b0;
		else
			array_commit <= cyc_end && !cyc_status;
	end

	// ------------------------------------------------------------
	// select and standby state
	// ------------------------------------------------------------
	// standby waits for the running write even after deselect
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			selected <= 1'b0;
			standby <= 1'b1;
		end
		else
		begin
			selected <= !sel_s; // [RULE_01]
			standby <= sel_s && !write_busy; // [RULE_01] [RULE_02]
		end
	end

	// status word offered to the link side for status reads
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			status_word <= '0;
		else
		begin
			status_word <= '0;
			status_word[ST_PEN] <= protect_pin_enable;
			status_word[ST_BP1] <= block_protect[1];
			status_word[ST_BP0] <= block_protect[0];
			status_word[ST_WEL] <= write_enable_latch;
			status_word[ST_WIP] <= write_busy;
		end
	end

endmodule : serial_eeprom_select_protect

// ===== ssp_monitor.sv
// port-level assertions for the select, drive and protect block
`timescale 1ns/10ps
module ssp_monitor #(
	parameter int unsigned WRITE_CYCLES = 100
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// link pins
	input wire logic sel_n,
	input wire logic so_oe_n,
	// device state
	input wire logic selected,
	input wire logic standby,
	input wire logic write_busy,
	input wire logic write_enable_latch,
	input wire logic protect_pin_enable,
	input wire logic [1:0] block_protect,
	input wire logic array_commit
);
	int unsigned busy_cnt; // cycles of the running write
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// ------------------------------------------------------------
	// helper: length of the running write, judged when it ends
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			busy_cnt <= 0;
		else
			busy_cnt <= write_busy ? busy_cnt + 1 : 0;
	end

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_float;
		sel_n |-> so_oe_n;
	endproperty
	a_float: assert property (p_float)
		else $error("serial output driven while deselected");
	// sync delay is three cycles, five leaves margin
	property p_sel;
		(!sel_n) [*5] |-> selected;
	endproperty
	a_sel: assert property (p_sel)
		else $error("select low but device not selected");
	property p_desel;
		(sel_n && !write_busy) [*6] |-> standby && !selected;
	endproperty
	a_desel: assert property (p_desel)
		else $error("deselected and idle but not in standby");
	property p_busy_stby;
		write_busy && $past(write_busy) |-> !standby;
	endproperty
	a_busy_stby: assert property (p_busy_stby)
		else $error("standby entered while a write runs");
	property p_start;
		$rose(write_busy) |-> sel_n && $past(write_enable_latch);
	endproperty
	a_start: assert property (p_start)
		else $error("write started without latch or while selected");
	property p_len;
		$fell(write_busy) |-> busy_cnt == WRITE_CYCLES;
	endproperty
	a_len: assert property (p_len)
		else $error("write cycle length wrong");
	property p_wel_end;
		$fell(write_busy) |-> !write_enable_latch;
	endproperty
	a_wel_end: assert property (p_wel_end)
		else $error("write enable latch kept after write");
	property p_hold;
		write_busy && $past(write_busy) |->
			$stable(protect_pin_enable) && $stable(block_protect);
	endproperty
	a_hold: assert property (p_hold)
		else $error("status bits moved during a write");
	property p_commit;
		array_commit |-> $fell(write_busy);
	endproperty
	a_commit: assert property (p_commit)
		else $error("array commit not at write end");

	// main scenarios reached
	c_write: cover property ($rose(write_busy));
	c_commit: cover property (array_commit);
	c_drive: cover property ($fell(so_oe_n));
endmodule : ssp_monitor

// ===== ssp_master.sv
// link master model driving select, link clock and serial data
`timescale 1ns/10ps
module ssp_master #(
	parameter int HALF = 16, // half link period, ns
	parameter int GAP = 300 // deselect time, covers drain plus 4 clk
) (
	// link pins
	output logic sck,
	output logic sel_n,
	output logic si,
	input wire logic so
);
	// link clock stands low between frames
	initial
	begin
		sck = 1'b0;
		sel_n = 1'b1;
		si = 1'b0;
	end

	// one frame, msb first; read bits taken on rising link clock
	task automatic xfer(input logic [47:0] tx, input int nbits,
		output logic [47:0] rx);
		rx = '0;
		#3 sel_n = 1'b0;
		for (int i = nbits - 1; i >= 0; i--)
		begin
			si = tx[i];
			#HALF sck = 1'b1;
			rx = {rx[46:0], so};
			#HALF sck = 1'b0;
		end
		#HALF sel_n = 1'b1;
		si = ~si; // released line shows no stale bit
		#GAP;
	endtask : xfer
endmodule : ssp_master

// ===== serial_eeprom_select_protect_test.sv
// self-checking bench for the select, drive and protect block
`timescale 1ns/10ps
module serial_eeprom_select_protect_test;
	import ssp_pkg::*;
	localparam int unsigned WCYC = 100; // shortened write time
	localparam int LIMIT = 40000; // clk cycles before giving up
	logic clk, rstn, wp_n, rx_ready, sck, sel_n, si, so, so_oe_n;
	logic selected, standby, write_busy, wel, pen, array_commit;
	logic rx_first, rx_valid;
	logic [1:0] bp;
	logic [7:0] rx_byte;
	wire so_line = so_oe_n ? 1'bz : so; // floats when released
	int failures, n_tests, cycles, n_starts, n_commits;
	logic busy_q;
	logic [8:0] rxq[$]; // accepted bytes with first flag
	logic [47:0] rd; // last word read on the link

	serial_eeprom_select_protect #(.WRITE_CYCLES(WCYC)) uut (
		.clk(clk), .rstn(rstn), .sck(sck), .sel_n(sel_n), .si(si),
		.so(so), .so_oe_n(so_oe_n), .wp_n(wp_n), .selected(selected),
		.standby(standby), .write_busy(write_busy),
		.write_enable_latch(wel), .protect_pin_enable(pen),
		.block_protect(bp), .rx_byte(rx_byte), .rx_first(rx_first),
		.rx_valid(rx_valid), .rx_ready(rx_ready),
		.array_commit(array_commit));
	ssp_master m (.sck(sck), .sel_n(sel_n), .si(si), .so(so_line));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// event counters, byte capture and hang guard
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		busy_q <= write_busy;
		if (write_busy === 1'b1 && busy_q !== 1'b1)
			n_starts++;
		if (array_commit === 1'b1)
			n_commits++;
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			rxq.push_back({rx_first, rx_byte});
		cycles++;
		if (cycles == LIMIT)
		begin
			failures++;
			print_verdict();
		end
	end

	task automatic chk(input string what, input logic [8:0] exp,
		input logic [8:0] got);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// status byte: enable, two protect bits, latch, busy
	function automatic logic [8:0] st(input logic p, input logic [1:0] b,
		input logic w, input logic ip);
		return {1'b0, p, 3'h0, b, w, ip};
	endfunction : st

	task automatic send(input logic [47:0] tx, input int nbits);
		m.xfer(tx, nbits, rd);
	endtask : send

	// wait out a write if one starts; bounded both ways
	task automatic settle();
		int k;
		k = 0;
		while (write_busy !== 1'b1 && k < 100)
		begin
			@(posedge clk);
			k++;
		end
		while (write_busy === 1'b1 && k < WCYC + 200)
		begin
			@(posedge clk);
			k++;
		end
		repeat (8) @(posedge clk);
		chk("standby", 9'h001, {8'h0, standby});
	endtask : settle

	task automatic t_select();
		send(8'h06, 8); // only arms the device
		settle();
		chk("wel unarmed", 9'h000, {8'h0, wel});
		send(8'h06, 8);
		settle();
		chk("wel set", 9'h001, {8'h0, wel});
		send(8'h04, 8);
		settle();
		chk("wel clear", 9'h000, {8'h0, wel});
		send({8'h06, 3'h5}, 11); // odd trailing bits
		settle();
		chk("wel partial", 9'h000, {8'h0, wel});
		send(8'h06, 8);
		send({8'h05, 8'h00}, 16);
		chk("status", st(1'b0, 2'h0, 1'b1, 1'b0), {1'b0, rd[7:0]});
		chk("so released", 9'h001, {8'h0, so_oe_n});
		$display("test select done");
	endtask : t_select

	task automatic t_protect();
		int s;
		s = n_starts;
		send({8'h01, 8'h8c}, 16);
		send({8'h05, 8'h00}, 16); // polled while the write runs
		chk("status busy", st(1'b0, 2'h0, 1'b1, 1'b1), {1'b0, rd[7:0]});
		settle();
		chk("pen", 9'h001, {8'h0, pen});
		chk("bp", 9'h003, {7'h0, bp});
		chk("wel end", 9'h000, {8'h0, wel});
		chk("starts", 9'(s + 1), 9'(n_starts));
		@(posedge clk) wp_n <= 1'b0;
		send(8'h06, 8);
		send({8'h01, 8'h00}, 16);
		settle();
		chk("pen locked", 9'h001, {8'h0, pen});
		chk("bp locked", 9'h003, {7'h0, bp});
		chk("wel kept", 9'h001, {8'h0, wel});
		send(8'h04, 8);
		settle();
		chk("wel others", 9'h000, {8'h0, wel});
		@(posedge clk) wp_n <= 1'b1;
		send(8'h06, 8);
		send({8'h01, 8'h84}, 16);
		@(posedge clk) wp_n <= 1'b0; // pin drops mid-write
		chk("busy", 9'h001, {8'h0, write_busy});
		settle();
		chk("bp late", 9'h001, {7'h0, bp});
		@(posedge clk) wp_n <= 1'b1;
		send(8'h06, 8);
		send({8'h01, 8'h00}, 16);
		settle();
		@(posedge clk) wp_n <= 1'b0; // pin grounded
		send(8'h06, 8);
		send({8'h01, 8'h08}, 16);
		settle();
		chk("pen off", 9'h000, {8'h0, pen});
		chk("bp grounded", 9'h002, {7'h0, bp});
		$display("test protect done");
	endtask : t_protect

	task automatic t_array();
		int s;
		int c;
		logic [8:0] exp[4];
		exp = '{9'h102, 9'h000, 9'h010, 9'h055};
		s = n_starts;
		c = n_commits;
		send(8'h06, 8);
		@(posedge clk) rx_ready <= 1'b0; // consumer stalls
		send({8'h02, 8'h00, 8'h10, 8'h55, 8'haa, 8'hbb}, 48);
		@(posedge clk) rx_ready <= 1'b1;
		settle();
		chk("overflow", 9'(s), 9'(n_starts));
		chk("wel overflow", 9'h001, {8'h0, wel});
		rxq.delete();
		@(posedge clk) rx_ready <= 1'b0;
		send({8'h02, 8'h00, 8'h10, 8'h55}, 32);
		@(posedge clk) rx_ready <= 1'b1;
		settle();
		chk("array starts", 9'(s + 1), 9'(n_starts));
		chk("commits", 9'(c + 1), 9'(n_commits));
		chk("rx count", 9'h004, 9'(rxq.size()));
		for (int i = 0; i < 4; i++)
			chk("rx byte", exp[i], rxq[i]);
		$display("test array done");
	endtask : t_array

	task automatic print_verdict();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	initial
	begin
		rstn = 1'b0;
		wp_n = 1'b1;
		rx_ready = 1'b1;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		t_select();
		t_protect();
		t_array();
		print_verdict();
	end
endmodule : serial_eeprom_select_protect_test

bind serial_eeprom_select_protect ssp_monitor #(
	.WRITE_CYCLES(WRITE_CYCLES)) mon (.clk(clk), .rstn(rstn),
	.sel_n(sel_n), .so_oe_n(so_oe_n), .selected(selected),
	.standby(standby), .write_busy(write_busy),
	.write_enable_latch(write_enable_latch),
	.protect_pin_enable(protect_pin_enable),
	.block_protect(block_protect), .array_commit(array_commit));
